/* File: verilog/smt_defs.vh */
// constants for the signal measure timer core: register map, fields, codes
// assumes 32-bit ahb-lite data, one aligned word per register
//
// How it works
// RULE1: a 24-bit up-counter is the time base in every mode
// RULE2: clock source field picks system, system/4, internal or secondary clock
// RULE3: two-bit prescale divides the chosen clock; it clocks counter and synchronizers
// RULE4: counter equal to period register rolls over to zero, raising period match
// RULE5: software sets period above the longest expected signal or window
// RULE6: counter-clear bit in status register forces the counter to zero
// RULE7: software touches the counter only while run control is zero
// RULE8: 24-bit pulse-width latch captures the counter on the mode's trigger
// RULE9: width update bit copies the counter into the pulse-width latch
// RULE10: 24-bit period latch captures the counter on the mode's period trigger
// RULE11: period update bit copies the counter into the period latch
// RULE12: halt-on-match stops the counter at match instead of rolling over
// RULE13: while halting, match flag stays set until counter is cleared or rewritten
// RULE14: window, signal and clock inputs each have their own polarity bit
// RULE15: window level flag shows raw window level, lagging by synchronizers
// RULE16: signal level flag shows raw signal level, lagging by synchronizers
// RULE17: software may write period, pulse-width and period latch registers directly
// RULE18: counter advances on prescaled ticks only while running and mode allows
// RULE19: match flag stays set until software clears it
`ifndef SMT_DEFS_VH
`define SMT_DEFS_VH

// register byte offsets
`define SMT_OFF_COUNTER 8'h00
`define SMT_OFF_PERIOD 8'h04
`define SMT_OFF_WIDTH 8'h08
`define SMT_OFF_PLATCH 8'h0c
`define SMT_OFF_CTRL0 8'h10
`define SMT_OFF_CTRL1 8'h14
`define SMT_OFF_STATUS 8'h18
`define SMT_OFF_CLKSEL 8'h1c

// control register zero fields
`define SMT_C0_PS_LO 0
`define SMT_C0_HALT 2
`define SMT_C0_WPOL 3
`define SMT_C0_SPOL 4
`define SMT_C0_CPOL 5
// control register one fields
`define SMT_C1_RUN 0
`define SMT_C1_MODE_LO 1
// status register fields
`define SMT_ST_CLEAR 0
`define SMT_ST_WUP 1
`define SMT_ST_PUP 2
`define SMT_ST_WLEV 3
`define SMT_ST_SLEV 4
`define SMT_ST_ACT 5
`define SMT_ST_MATCH 6

// measurement modes
`define SMT_MODE_TIMER 2'h0
`define SMT_MODE_GATED 2'h1
`define SMT_MODE_PERDUTY 2'h2

// clock source codes
`define SMT_CS_SYS 3'h0
`define SMT_CS_SYS4 3'h1
`define SMT_CS_EXT 3'h7
// first of the five source tick codes, src_tick[0]
`define SMT_CS_SRC0 3'h2
// last phase of the free system/4 divider
`define SMT_SYS4_LAST 2'h3

// reset values
`define SMT_RST_COUNT 24'h00_0000
`define SMT_RST_PERIOD 24'hff_ffff
`define SMT_RST_CTRL 6'h00
`define SMT_RST_SEL 3'h0

`endif

/* File: verilog/smt_presc.v */
// clock source selection and prescaler, producing a one-cycle count tick
// assumes source ticks are single-cycle pulses synchronous to clk
`timescale 1ns/1ps
`include "smt_defs.vh"

module smt_presc
(
   input wire clk,
   input wire reset_n,
   input wire [2:0] clock_source_field,
   input wire [1:0] ps,
   input wire [4:0] src_tick,
   input wire ext_tick,
   output wire tick
);

reg [1:0] div4_r;
reg [2:0] pcnt_r;
reg sel_tick;
wire [2:0] pmask;

// system clock divided by four, free running
always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
      div4_r <= 2'h0;
   else
      div4_r <= div4_r + 2'h1;
end

// source selector
always @*
begin
   if (clock_source_field == `SMT_CS_SYS)
      sel_tick = 1'b1;
   else if (clock_source_field == `SMT_CS_SYS4)
      sel_tick = (div4_r == `SMT_SYS4_LAST);
   else if (clock_source_field == `SMT_CS_EXT)
      sel_tick = ext_tick;
   else
      sel_tick = src_tick[clock_source_field - `SMT_CS_SRC0];
end

// 1:1, 1:2, 1:4, 1:8 divide of the selected tick
assign pmask = (3'h1 << ps) - 3'h1; // RULE3
assign tick = sel_tick && ((pcnt_r & pmask) == pmask); // RULE3

always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
      pcnt_r <= 3'h0;
   else if (sel_tick)
      pcnt_r <= pcnt_r + 3'h1;
end

endmodule // smt_presc

/* File: verilog/smt_core.v */
// signal measure timer core with an ahb-lite register slave
// assumes one clock, all pins synchronous to clk, a single bus master
`timescale 1ns/1ps
`include "smt_defs.vh"

module smt_core
#(
   parameter CW = 24
)
(
   input wire clk,
   input wire reset_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire [4:0] src_tick,
   input wire window_in,
   input wire signal_in,
   input wire clock_in,
   output wire match_irq
);

// registers
reg [CW-1:0] measure_counter_r;
reg [CW-1:0] period_register_r;
reg [CW-1:0] pulse_width_latch_r;
reg [CW-1:0] period_latch_r;
reg [5:0] control_register_zero_r;
reg [2:0] control_register_one_r;
reg [2:0] clock_select_register_r;
reg match_r;

// bus state
reg wr_pend_r;
reg rd_wait_r;
reg [7:0] addr_r;
reg [31:0] hrdata_r;
reg [31:0] rd_nxt;

// input synchronizers on the prescaled tick; clock pin delay on clk
reg win_s1_r;
reg win_s2_r;
reg sig_s1_r;
reg sig_s2_r;
reg win_act_d_r;
reg sig_act_d_r;
reg clk_pin_d_r;

wire tick;
wire run_control;
wire halt_on_match;
wire [1:0] mode;
wire win_act;
wire sig_act;
wire clk_act;
wire ext_tick;
wire count_en;
wire at_match;
wire sig_rise;
wire sig_fall;
wire win_fall;
wire accept;
wire wr_counter;
wire wr_status;
wire sw_clear;
wire sw_wup;
wire sw_pup;
wire sw_match_clr;
wire measure_active_flag;

// address hit on a latched offset
function hit;
   input [7:0] a;
   input [7:0] off;
   begin
      hit = (a == off);
   end
endfunction

assign run_control = control_register_one_r[`SMT_C1_RUN];
assign mode = control_register_one_r[`SMT_C1_MODE_LO +: 2];
assign halt_on_match = control_register_zero_r[`SMT_C0_HALT];

// polarity: bit set means active low or falling edge
assign win_act = win_s2_r ^ control_register_zero_r[`SMT_C0_WPOL]; // RULE14
assign sig_act = sig_s2_r ^ control_register_zero_r[`SMT_C0_SPOL]; // RULE14
assign clk_act = clock_in ^ control_register_zero_r[`SMT_C0_CPOL]; // RULE14

// external clock pin edge, sampled on clk since it feeds the prescaler
assign ext_tick = clk_act && !clk_pin_d_r;

smt_presc u_presc
(
   .clk(clk),
   .reset_n(reset_n),
   .clock_source_field(clock_select_register_r), // RULE2
   .ps(control_register_zero_r[`SMT_C0_PS_LO +: 2]), // RULE3
   .src_tick(src_tick), // RULE2
   .ext_tick(ext_tick),
   .tick(tick)
);

always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
      clk_pin_d_r <= 1'b0;
   else
      clk_pin_d_r <= clk_act;
end

// synchronizers run on the prescaled tick, so a slow clock adds lag
always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
   begin
      win_s1_r <= 1'b0;
      win_s2_r <= 1'b0;
      sig_s1_r <= 1'b0;
      sig_s2_r <= 1'b0;
      win_act_d_r <= 1'b0;
      sig_act_d_r <= 1'b0;
   end
   else if (tick) // RULE3
   begin
      win_s1_r <= window_in;
      win_s2_r <= win_s1_r;
      sig_s1_r <= signal_in;
      sig_s2_r <= sig_s1_r;
      win_act_d_r <= win_act;
      sig_act_d_r <= sig_act;
   end
end

assign sig_rise = sig_act && !sig_act_d_r;
assign sig_fall = !sig_act && sig_act_d_r;
assign win_fall = !win_act && win_act_d_r;

// mode gate: timer and period-duty always count, gated counts in window
assign count_en = (mode == `SMT_MODE_TIMER) ||
                  (mode == `SMT_MODE_PERDUTY) ||
                  ((mode == `SMT_MODE_GATED) && win_act);
assign measure_active_flag = run_control && count_en;
assign at_match = (measure_counter_r == period_register_r); // RULE4

// bus: accept address phase, reads take one wait state
assign accept = hsel && htrans[1] && hready;
assign hreadyout = !rd_wait_r;
assign hresp = 1'b0;
assign hrdata = hrdata_r;

always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
   begin
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r <= 8'h00;
   end
   else
   begin
      wr_pend_r <= accept && hwrite;
      rd_wait_r <= accept && !hwrite;
      if (accept)
         addr_r <= {haddr[7:2], 2'b00};
   end
end

// write strobes in the data phase
assign wr_counter = wr_pend_r && hit(addr_r, `SMT_OFF_COUNTER);
assign wr_status = wr_pend_r && hit(addr_r, `SMT_OFF_STATUS);
assign sw_clear = wr_status && hwdata[`SMT_ST_CLEAR];
assign sw_wup = wr_status && hwdata[`SMT_ST_WUP];
assign sw_pup = wr_status && hwdata[`SMT_ST_PUP];
assign sw_match_clr = wr_status && hwdata[`SMT_ST_MATCH];

// read mux, loaded in the wait cycle so a preceding write is visible
always @*
begin
   rd_nxt = 32'h0000_0000;
   if (hit(addr_r, `SMT_OFF_COUNTER))
      rd_nxt[CW-1:0] = measure_counter_r;
   else if (hit(addr_r, `SMT_OFF_PERIOD))
      rd_nxt[CW-1:0] = period_register_r;
   else if (hit(addr_r, `SMT_OFF_WIDTH))
      rd_nxt[CW-1:0] = pulse_width_latch_r;
   else if (hit(addr_r, `SMT_OFF_PLATCH))
      rd_nxt[CW-1:0] = period_latch_r;
   else if (hit(addr_r, `SMT_OFF_CTRL0))
      rd_nxt[5:0] = control_register_zero_r;
   else if (hit(addr_r, `SMT_OFF_CTRL1))
      rd_nxt[2:0] = control_register_one_r;
   else if (hit(addr_r, `SMT_OFF_STATUS))
   begin
      rd_nxt[`SMT_ST_WLEV] = win_s2_r; // RULE15
      rd_nxt[`SMT_ST_SLEV] = sig_s2_r; // RULE16
      rd_nxt[`SMT_ST_ACT] = measure_active_flag;
      rd_nxt[`SMT_ST_MATCH] = match_r;
   end
   else if (hit(addr_r, `SMT_OFF_CLKSEL))
      rd_nxt[2:0] = clock_select_register_r;
end

always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
      hrdata_r <= 32'h0000_0000;
   else if (rd_wait_r)
      hrdata_r <= rd_nxt;
end

// configuration registers
always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
   begin
      control_register_zero_r <= `SMT_RST_CTRL;
      control_register_one_r <= `SMT_RST_SEL;
      clock_select_register_r <= `SMT_RST_SEL;
      period_register_r <= `SMT_RST_PERIOD;
   end
   else if (wr_pend_r)
   begin
      if (hit(addr_r, `SMT_OFF_CTRL0))
         control_register_zero_r <= hwdata[5:0];
      else if (hit(addr_r, `SMT_OFF_CTRL1))
         control_register_one_r <= hwdata[2:0];
      else if (hit(addr_r, `SMT_OFF_CLKSEL))
         clock_select_register_r <= hwdata[2:0];
      else if (hit(addr_r, `SMT_OFF_PERIOD))
         period_register_r <= hwdata[CW-1:0]; // RULE17 RULE5
   end
end

// counter: clear, then software write, then counting
always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
      measure_counter_r <= `SMT_RST_COUNT;
   else if (sw_clear)
      measure_counter_r <= `SMT_RST_COUNT; // RULE6
   else if (wr_counter)
      measure_counter_r <= hwdata[CW-1:0]; // RULE7
   else if (tick && run_control) // RULE18
   begin
      if ((mode == `SMT_MODE_PERDUTY) && sig_rise)
         measure_counter_r <= `SMT_RST_COUNT; // RULE10
      else if (count_en)
      begin
         if (at_match && halt_on_match)
            measure_counter_r <= measure_counter_r; // RULE12
         else if (at_match)
            measure_counter_r <= `SMT_RST_COUNT; // RULE4
         else
            measure_counter_r <= measure_counter_r + 1'b1; // RULE1
      end
   end
end

// match flag: set wins over clear; a halted counter re-sets it every tick
always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
      match_r <= 1'b0;
   else if (tick && run_control && count_en && at_match)
      match_r <= 1'b1; // RULE4 RULE13
   else if (sw_match_clr)
      match_r <= 1'b0; // RULE19
end

assign match_irq = match_r; // RULE4

// pulse-width latch: software copy or write, then mode trigger
always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
      pulse_width_latch_r <= `SMT_RST_COUNT;
   else if (sw_wup)
      pulse_width_latch_r <= measure_counter_r; // RULE9
   else if (wr_pend_r && hit(addr_r, `SMT_OFF_WIDTH))
      pulse_width_latch_r <= hwdata[CW-1:0]; // RULE17
   else if (tick && run_control)
   begin
      if ((mode == `SMT_MODE_PERDUTY) && sig_fall)
         pulse_width_latch_r <= measure_counter_r; // RULE8
      else if ((mode == `SMT_MODE_GATED) && win_fall)
         pulse_width_latch_r <= measure_counter_r; // RULE8
   end
end

// period latch: software copy or write, then signal active edge
always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
      period_latch_r <= `SMT_RST_COUNT;
   else if (sw_pup)
      period_latch_r <= measure_counter_r; // RULE11
   else if (wr_pend_r && hit(addr_r, `SMT_OFF_PLATCH))
      period_latch_r <= hwdata[CW-1:0]; // RULE17
   else if (tick && run_control && (mode == `SMT_MODE_PERDUTY) && sig_rise)
      period_latch_r <= measure_counter_r; // RULE10
end

endmodule // smt_core

/* File: testbench/smt_chk.sv */
// checker for the measure timer core: bus timing, read width, match flag
// assumes it is bound to smt_core, hready tied to hreadyout
`timescale 1ns/1ps
module smt_chk
(
   input wire clk,
   input wire reset_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire match_irq
);
   wire tk = hsel && htrans[1] && hready;
   reg st_wr_r;
   wire rd_tk = tk && !hwrite;
   wire match_clr = st_wr_r && hwdata[6];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // marks the data phase of a status write, when a flag clear lands
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         st_wr_r <= 1'b0;
      else
         st_wr_r <= tk && hwrite && haddr[7:2] == 6'h06;
   end
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_rd_wait; tk && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_nowait; tk && hwrite |=> hreadyout; endproperty
   a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
   property p_idle; !tk && hreadyout |=> hreadyout; endproperty
   a_idle: assert property (p_idle) else $error("stall without read");
   property p_one_wait; !hreadyout |=> hreadyout; endproperty
   a_one_wait: assert property (p_one_wait) else $error("stall too long");
   property p_cause; $fell(hreadyout) |-> $past(rd_tk); endproperty
   a_cause: assert property (p_cause) else $error("stall with no read");
   property p_upper; !$past(hreadyout) && hreadyout |-> hrdata[31:24] == 8'h00; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_hold; $fell(match_irq) |-> $past(match_clr); endproperty
   a_hold: assert property (p_hold) else $error("match flag dropped alone");
endmodule // smt_chk

bind smt_core smt_chk u_chk (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .match_irq(match_irq));

/* File: testbench/testbench.sv */
// self-checking bench for the measure timer core over ahb-lite
// assumes hready tied to hreadyout; the bench drives source ticks and the clock pin
`timescale 1ns/1ps
`include "smt_defs.vh"
module testbench;
   reg clk, reset_n, hsel, hwrite, window_in, signal_in, clock_in;
   reg [31:0] haddr, hwdata, q;
   reg [1:0] htrans;
   reg [4:0] src_tick;
   wire [31:0] hrdata;
   wire hreadyout, hresp, match_irq;
   integer mismatches = 0, total_checks = 0, i;
   smt_core DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .src_tick(src_tick), .window_in(window_in),
      .signal_in(signal_in), .clock_in(clock_in), .match_irq(match_irq));
   task chk(input [31:0] seen, input [31:0] exp);
   begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   end
   endtask
   // one single transfer; ready and read data are taken at rising edges
   task xf(input w, input [7:0] a, input [31:0] d);
   begin
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      q = hrdata;
   end
   endtask
   task rc(input [7:0] a, input [31:0] e);
   begin
      xf(1'b0, a, 32'h0);
      chk(q, e);
   end
   endtask
   // counts may slip up to two ticks either way against the bus cycles
   task nr(input [7:0] a, input [23:0] e);
   begin
      xf(1'b0, a, 32'h0);
      chk({31'h0, (q[23:0] + 24'h2 - e) <= 24'h4}, 32'h1);
   end
   endtask
   task cm(input e);
   begin
      @(negedge clk);
      chk({31'h0, match_irq}, {31'h0, e});
   end
   endtask
   task t_regs;
   begin
      rc(`SMT_OFF_PERIOD, 32'h00ff_ffff);
      rc(`SMT_OFF_PLATCH, 32'h0);
      cm(1'b0);
      for (i = 0; i < 4; i = i + 1)
      begin
         xf(1'b1, {i[5:0], 2'b00}, 32'hffff_ffff);
         rc({i[5:0], 2'b00}, 32'h00ff_ffff);
      end
      xf(1'b1, 8'h24, 32'h5);
      rc(8'h24, 32'h0);
      $display("registers done");
   end
   endtask
   task t_halt;
   begin
      xf(1'b1, `SMT_OFF_COUNTER, 32'h0);
      xf(1'b1, `SMT_OFF_PERIOD, 32'h3);
      xf(1'b1, `SMT_OFF_CTRL0, 32'h4);
      xf(1'b1, `SMT_OFF_CTRL1, 32'h1);
      repeat (30) @(posedge clk);
      rc(`SMT_OFF_COUNTER, 32'h3);
      xf(1'b1, `SMT_OFF_STATUS, 32'h40);
      cm(1'b1);
      xf(1'b1, `SMT_OFF_CTRL1, 32'h0);
      xf(1'b1, `SMT_OFF_STATUS, 32'h41);
      rc(`SMT_OFF_COUNTER, 32'h0);
      cm(1'b0);
      xf(1'b1, `SMT_OFF_CTRL0, 32'h0);
      xf(1'b1, `SMT_OFF_CTRL1, 32'h1);
      repeat (20) @(posedge clk);
      cm(1'b1);
      xf(1'b1, `SMT_OFF_CTRL1, 32'h0);
      xf(1'b0, `SMT_OFF_COUNTER, 32'h0);
      chk({31'h0, q[23:0] < 24'h4}, 32'h1);
      $display("match done");
   end
   endtask
   // free count over a fixed span for each prescale, then system/4
   task t_presc;
   begin
      xf(1'b1, `SMT_OFF_PERIOD, 32'h00ff_ffff);
      for (i = 0; i < 5; i = i + 1)
      begin
         xf(1'b1, `SMT_OFF_COUNTER, 32'h0);
         xf(1'b1, `SMT_OFF_CLKSEL, {31'h0, i == 4});
         xf(1'b1, `SMT_OFF_CTRL0, (i == 4) ? 32'h0 : i);
         xf(1'b1, `SMT_OFF_CTRL1, 32'h1);
         repeat (64) @(posedge clk);
         xf(1'b1, `SMT_OFF_CTRL1, 32'h0);
         nr(`SMT_OFF_COUNTER, 24'd67 >> ((i == 4) ? 2 : i));
      end
      xf(1'b1, `SMT_OFF_CLKSEL, 32'h0);
      xf(1'b1, `SMT_OFF_CTRL0, 32'h0);
      xf(1'b1, `SMT_OFF_COUNTER, 32'h0);
      xf(1'b1, `SMT_OFF_CTRL1, 32'h7);
      repeat (20) @(posedge clk);
      xf(1'b1, `SMT_OFF_CTRL1, 32'h0);
      rc(`SMT_OFF_COUNTER, 32'h0);
      $display("prescale done");
   end
   endtask
   // period and duty capture, for both signal polarities
   task t_cap;
   begin
      for (i = 0; i < 2; i = i + 1)
      begin
         xf(1'b1, `SMT_OFF_CTRL0, i << 4);
         xf(1'b1, `SMT_OFF_CTRL1, 32'h5);
         repeat (4)
         begin
            signal_in <= 1'b1;
            repeat (10) @(posedge clk);
            signal_in <= 1'b0;
            repeat (30) @(posedge clk);
         end
         signal_in <= 1'b1;
         window_in <= 1'b1;
         repeat (10) @(posedge clk);
         xf(1'b0, `SMT_OFF_STATUS, 32'h0);
         chk(q[5:3], 3'h7);
         xf(1'b1, `SMT_OFF_CTRL1, 32'h0);
         window_in <= 1'b0;
         nr(`SMT_OFF_WIDTH, i ? 24'd30 : 24'd10);
         nr(`SMT_OFF_PLATCH, 24'd40);
      end
      xf(1'b1, `SMT_OFF_COUNTER, 32'h123);
      xf(1'b1, `SMT_OFF_STATUS, 32'h2);
      rc(`SMT_OFF_WIDTH, 32'h123);
      xf(1'b1, `SMT_OFF_STATUS, 32'h4);
      rc(`SMT_OFF_PLATCH, 32'h123);
      $display("capture done");
   end
   endtask
   // gated counting over a 20-cycle window, both window polarities
   task t_gate;
   begin
      for (i = 0; i < 2; i = i + 1)
      begin
         window_in <= i[0];
         xf(1'b1, `SMT_OFF_CTRL0, i << 3);
         xf(1'b1, `SMT_OFF_COUNTER, 32'h0);
         xf(1'b1, `SMT_OFF_WIDTH, 32'h0);
         xf(1'b1, `SMT_OFF_CTRL1, 32'h3);
         repeat (10) @(posedge clk);
         xf(1'b0, `SMT_OFF_STATUS, 32'h0);
         chk({q[5], q[3]}, {1'b0, i[0]});
         window_in <= !i[0];
         repeat (20) @(posedge clk);
         window_in <= i[0];
         repeat (20) @(posedge clk);
         xf(1'b1, `SMT_OFF_CTRL1, 32'h0);
         nr(`SMT_OFF_WIDTH, 24'd20);
         nr(`SMT_OFF_COUNTER, 24'd20);
      end
      $display("gate done");
   end
   endtask
   // slow source ticks, then the clock pin on both edges: 16 pulses each
   task t_src;
   begin
      for (i = 2; i < 9; i = i + 1)
      begin
         xf(1'b1, `SMT_OFF_COUNTER, 32'h0);
         xf(1'b1, `SMT_OFF_CLKSEL, (i == 8) ? 32'h7 : i);
         xf(1'b1, `SMT_OFF_CTRL0, (i == 8) ? 32'h20 : 32'h0);
         xf(1'b1, `SMT_OFF_CTRL1, 32'h1);
         repeat (16)
         begin
            src_tick <= (i < 7) ? (5'h1 << (i - 2)) : 5'h0;
            clock_in <= 1'b1;
            @(posedge clk);
            src_tick <= 5'h0;
            clock_in <= 1'b0;
            repeat (3) @(posedge clk);
         end
         xf(1'b1, `SMT_OFF_CTRL1, 32'h0);
         rc(`SMT_OFF_COUNTER, 32'h10);
      end
      $display("sources done");
   end
   endtask
   task end_sim;
   begin
      $display("%0d checks, %0d mismatches", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   // 8 ns clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // main sequence
   initial
   begin
      {reset_n, hsel, hwrite, window_in, signal_in, clock_in} = 6'h0;
      {haddr, hwdata, htrans, src_tick} = 71'h0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      t_regs;
      t_halt;
      t_presc;
      t_cap;
      t_gate;
      t_src;
      end_sim;
   end
   // the run needs about 1700 cycles; this cuts a hang
   initial
   begin
      #100000;
      mismatches = mismatches + 1;
      end_sim;
   end
endmodule // testbench
